// ---- pkg/irwd_pkg.sv ----
`default_nettype none
package irwd_pkg;
    localparam int NUM_SRC = 7;
    // request/enable bit positions
    localparam int SRC_PORTC = 0;
    localparam int SRC_TIM1  = 1;
    localparam int SRC_EXT   = 2;
    localparam int SRC_PRE   = 3;
    localparam int SRC_TIM2  = 4;
    localparam int SRC_KEY   = 5;
    localparam int SRC_RCNV  = 6;
    localparam logic [11:0] VEC_EXT   = 12'h010;
    localparam logic [11:0] VEC_PORTC = 12'h014;
    localparam logic [11:0] VEC_TIM1  = 12'h018;
    localparam logic [11:0] VEC_PRE   = 12'h01C;
    localparam logic [11:0] VEC_TIM2  = 12'h020;
    localparam logic [11:0] VEC_KEY   = 12'h024;
    localparam logic [11:0] VEC_RCNV  = 12'h028;
    localparam logic [11:0] PC_RESET  = 12'h000;
    localparam logic [6:0]  FLAGS_RST = 7'h00;
    localparam logic [7:0]  WD_KICK_OPND = 8'h10;
    localparam int RST_LONG_STAGE0  = 16384;
    localparam int RST_SHORT_STAGE0 = 2048;
    localparam int WD_WIDTH = 9;
    localparam logic [8:0] WD_IVL_8   = 9'h007;
    localparam logic [8:0] WD_IVL_64  = 9'h03F;
    localparam logic [8:0] WD_IVL_512 = 9'h1FF;
    localparam int WD_SEL_8   = 0;
    localparam int WD_SEL_64  = 1;
    localparam int WD_SEL_512 = 2;
endpackage
`default_nettype wire

// ---- pkg/irwd_wd_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface irwd_wd_if;
    logic       clear;
    logic       freeze;
    logic       tick;
    logic       run;
    logic       overflow;
    modport ctrl (output clear, output freeze, output tick, output run,
                  input overflow);
    modport wdog (input clear, input freeze, input tick, input run,
                  output overflow);
endinterface
`default_nettype wire

// ---- rtl/irwd_watchdog.sv ----
`timescale 1ns/100ps
`default_nettype none
module irwd_watchdog
    import irwd_pkg::*;
#(
    parameter int WD_SEL = WD_SEL_512
) (
    input  wire logic core_clk_i,
    input  wire logic rst_i,
    irwd_wd_if.wdog   wd
);
    logic [WD_WIDTH-1:0] count;
    logic [WD_WIDTH-1:0] limit;

    always_comb begin
        case (WD_SEL)
            WD_SEL_8:  limit = WD_IVL_8;
            WD_SEL_64: limit = WD_IVL_64;
            default:   limit = WD_IVL_512;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i || wd.clear || !wd.run) begin
            count <= '0;
        end else if (wd.tick && !wd.freeze) begin
            // restart on overflow so each interval is full length
            count <= (count == limit) ? '0 : count + 9'h001;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i || wd.clear || !wd.run) begin
            wd.overflow <= 1'b0;
        end else begin
            wd.overflow <= wd.tick && !wd.freeze && (count == limit);
        end
    end

    property p_wd_freeze;
        @(posedge core_clk_i) disable iff (rst_i)
        (wd.freeze && wd.run && !wd.clear) |=> (count == $past(count));
    endproperty
    a_wd_freeze: assert property (p_wd_freeze)
        else $error("watchdog moved while frozen");

    property p_wd_count;
        @(posedge core_clk_i) disable iff (rst_i)
        (wd.run && wd.tick && !wd.freeze && !wd.clear && count != limit)
            |=> (count == $past(count) + 9'h001);
    endproperty
    a_wd_count: assert property (p_wd_count)
        else $error("watchdog count step wrong");
endmodule
`default_nettype wire

// ---- rtl/irwd_ctrl.sv ----
`timescale 1ns/100ps
`default_nettype none
module irwd_ctrl
    import irwd_pkg::*;
#(
    parameter bit          LONG_RESET = 1'b1,
    parameter bit          POR_USED   = 1'b1,
    parameter logic [3:0]  KEY_RST_EN = 4'hF,
    parameter int          WD_SEL     = WD_SEL_512,
    parameter int          RST_LONG   = RST_LONG_STAGE0,
    parameter int          RST_SHORT  = RST_SHORT_STAGE0
) (
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic        por_i,
    input  wire logic        reset_pin_i,
    input  wire logic [3:0]  key_in_i,
    input  wire logic        key_scan_mode_i,
    input  wire logic        key_scan_clk_i,
    input  wire logic        stage0_tick_i,
    input  wire logic        stage10_tick_i,
    input  wire logic        machine_cycle_i,
    input  wire logic        instr_boundary_i,
    input  wire logic [11:0] cur_pc_i,
    input  wire logic        cur_is_halt_i,
    input  wire logic        halt_mode_i,
    input  wire logic        stop_mode_i,
    input  wire logic        timer_one_uflow_i,
    input  wire logic        timer_two_uflow_i,
    input  wire logic        prescaler_ovf_i,
    input  wire logic        counter_stop_i,
    input  wire logic        counter_control_pin_mode_i,
    input  wire logic        port_c_match_i,
    input  wire logic        ext_edge_match_i,
    input  wire logic        key_scan_event_i,
    input  wire logic        set_irq_enables_instr_i,
    input  wire logic [6:0]  set_irq_enables_data_i,
    input  wire logic        clear_wake_requests_instr_i,
    input  wire logic [6:0]  clear_wake_requests_data_i,
    input  wire logic        set_flag_instr_i,
    input  wire logic [7:0]  set_flag_opnd_i,
    output logic [6:0]       wake_request_flag_o,
    output logic [6:0]       irq_enable_flag_o,
    output logic             watchdog_enable_flag_o,
    output logic             stack_push_o,
    output logic [11:0]      stack_data_o,
    output logic             pc_load_o,
    output logic [11:0]      pc_value_o,
    output logic             nop_insert_o,
    output logic             rehalt_pending_o,
    output logic             sys_reset_o,
    output logic             wd_reset_o
);
    typedef enum {
        ST_RUN,
        ST_NOP,
        ST_VEC
    } irwd_disp_t;

    localparam int RST_CNT = LONG_RESET ? RST_LONG : RST_SHORT;

    // ======================================================
    // priority and vectors
    function automatic logic [2:0] pick_src(input logic [6:0] p);
        if (p[SRC_PRE])        pick_src = 3'(SRC_PRE);
        else if (p[SRC_TIM1])  pick_src = 3'(SRC_TIM1);
        else if (p[SRC_TIM2])  pick_src = 3'(SRC_TIM2);
        else if (p[SRC_RCNV])  pick_src = 3'(SRC_RCNV);
        else if (p[SRC_PORTC]) pick_src = 3'(SRC_PORTC);
        else if (p[SRC_EXT])   pick_src = 3'(SRC_EXT);
        else                   pick_src = 3'(SRC_KEY);
    endfunction

    function automatic logic [11:0] vec_of(input logic [2:0] s);
        case (s)
            3'(SRC_PORTC): vec_of = VEC_PORTC;
            3'(SRC_TIM1):  vec_of = VEC_TIM1;
            3'(SRC_EXT):   vec_of = VEC_EXT;
            3'(SRC_PRE):   vec_of = VEC_PRE;
            3'(SRC_TIM2):  vec_of = VEC_TIM2;
            3'(SRC_KEY):   vec_of = VEC_KEY;
            default:       vec_of = VEC_RCNV;
        endcase
    endfunction

    // ======================================================
    // reset sequencing
    logic        pin_held;
    logic        in_cycle;
    logic        wd_cause;
    logic [15:0] rst_cnt;
    logic        key_all_zero;
    logic        key_req;
    logic        por_req;
    logic        start_cycle;
    logic        wd_ovf_seen;

    irwd_wd_if wd ();

    assign key_all_zero = (KEY_RST_EN != 4'h0) &&
                          ((key_in_i & KEY_RST_EN) == 4'h0);
    // scan mode waits for scan clock
    assign key_req = key_all_zero && (!key_scan_mode_i || key_scan_clk_i);
    assign por_req = POR_USED && por_i;
    assign wd_ovf_seen = wd.overflow;
    assign start_cycle = por_req || key_req || wd_ovf_seen || pin_held;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pin_held <= 1'b0;
        end else begin
            pin_held <= reset_pin_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            in_cycle <= 1'b1;
            rst_cnt  <= '0;
            wd_cause <= 1'b0;
        end else if (reset_pin_i || start_cycle) begin
            in_cycle <= 1'b1;
            rst_cnt  <= '0;
            wd_cause <= wd_ovf_seen && !reset_pin_i && !por_req && !key_req;
        end else if (in_cycle && stage0_tick_i) begin
            if (rst_cnt == 16'(RST_CNT - 1)) begin
                in_cycle <= 1'b0;
            end
            rst_cnt <= rst_cnt + 16'h0001;
        end
    end

    // reset output to ports, timers, clock
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            sys_reset_o <= 1'b1;
            wd_reset_o  <= 1'b0;
        end else begin
            sys_reset_o <= in_cycle || reset_pin_i || start_cycle;
            wd_reset_o  <= (in_cycle && wd_cause) ||
                           (wd_ovf_seen && !reset_pin_i && !por_req &&
                            !key_req);
        end
    end

    // ======================================================
    // watchdog enable
    logic hard_reset;
    assign hard_reset = reset_pin_i || por_req || key_req ||
                        (in_cycle && !wd_cause);

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            watchdog_enable_flag_o <= 1'b0;
        end else if (hard_reset) begin
            watchdog_enable_flag_o <= 1'b0;
        end else if (set_flag_instr_i && set_flag_opnd_i == WD_KICK_OPND) begin
            watchdog_enable_flag_o <= 1'b1;
        end
    end

    assign wd.clear  = set_flag_instr_i && set_flag_opnd_i == WD_KICK_OPND;
    assign wd.freeze = halt_mode_i || stop_mode_i;
    assign wd.tick   = stage10_tick_i;
    assign wd.run    = watchdog_enable_flag_o && !hard_reset;

    irwd_watchdog #(
        .WD_SEL (WD_SEL)
    ) u_wdog (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .wd         (wd)
    );

    // ======================================================
    // request flags and dispatch
    logic [6:0] events;
    logic [6:0] pending;
    logic [2:0] sel;
    logic [2:0] sel_q;
    logic       accept;
    irwd_disp_t state;

    always_comb begin
        events = 7'h00;
        events[SRC_TIM1]  = timer_one_uflow_i;
        events[SRC_TIM2]  = timer_two_uflow_i;
        events[SRC_PRE]   = prescaler_ovf_i;
        events[SRC_RCNV]  = counter_stop_i && counter_control_pin_mode_i;
        events[SRC_PORTC] = port_c_match_i;
        events[SRC_EXT]   = ext_edge_match_i;
        events[SRC_KEY]   = key_scan_event_i;
    end

    assign pending = wake_request_flag_o & irq_enable_flag_o;
    assign sel     = pick_src(pending);
    assign accept  = (state == ST_RUN) && (pending != 7'h00) &&
                     machine_cycle_i && instr_boundary_i && !sys_reset_o;

    always_ff @(posedge core_clk_i) begin
        if (rst_i || sys_reset_o) begin
            wake_request_flag_o <= FLAGS_RST;
        end else begin
            // set wins over clear
            // clear only accepted flag
            wake_request_flag_o <= (wake_request_flag_o
                & ~(accept ? (7'h01 << sel) : 7'h00)
                & ~(clear_wake_requests_instr_i ?
                    clear_wake_requests_data_i : 7'h00))
                | events;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i || sys_reset_o) begin
            irq_enable_flag_o <= FLAGS_RST;
        end else if (accept) begin
            irq_enable_flag_o <= FLAGS_RST;
        end else if (set_irq_enables_instr_i) begin
            irq_enable_flag_o <= set_irq_enables_data_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i || sys_reset_o) begin
            state <= ST_RUN;
            sel_q <= 3'h0;
        end else begin
            case (state)
                ST_RUN: begin
                    if (accept) begin
                        state <= ST_NOP;
                        sel_q <= sel;
                    end
                end
                ST_NOP:  state <= machine_cycle_i ? ST_VEC : ST_NOP;
                ST_VEC:  state <= ST_RUN;
                default: state <= ST_RUN;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i || sys_reset_o) begin
            stack_push_o     <= 1'b0;
            stack_data_o     <= PC_RESET;
            pc_load_o        <= rst_i || sys_reset_o;
            pc_value_o       <= PC_RESET;
            nop_insert_o     <= 1'b0;
            rehalt_pending_o <= 1'b0;
        end else begin
            stack_push_o <= accept;
            pc_load_o    <= (state == ST_NOP) && machine_cycle_i;
            nop_insert_o <= accept || (state == ST_NOP && !machine_cycle_i);
            if (accept) begin
                stack_data_o <= cur_pc_i;
                rehalt_pending_o <= cur_is_halt_i;
            end
            if (state == ST_NOP) begin
                pc_value_o <= vec_of(sel_q);
            end
        end
    end

    // ======================================================
    // checks
    // vector follows push
    property p_vec_after_push;
        @(posedge core_clk_i) disable iff (rst_i || sys_reset_o)
        stack_push_o |-> ##[1:40] pc_load_o;
    endproperty
    a_vec_after_push: assert property (p_vec_after_push)
        else $error("no vector load after push");

    property p_ief_clear;
        @(posedge core_clk_i) disable iff (rst_i)
        (accept && !sys_reset_o) |=> (irq_enable_flag_o == 7'h00);
    endproperty
    a_ief_clear: assert property (p_ief_clear)
        else $error("enables not cleared on accept");

    property p_pre_first;
        @(posedge core_clk_i) disable iff (rst_i || sys_reset_o)
        (accept && pending[SRC_PRE]) |=> ##1 (pc_value_o == VEC_PRE)
            or ##2 (pc_value_o == VEC_PRE);
    endproperty
    a_pre_first: assert property (p_pre_first)
        else $error("prescaler not served first");

    property p_others_kept;
        @(posedge core_clk_i) disable iff (rst_i || sys_reset_o)
        (accept && !clear_wake_requests_instr_i) |=>
            ((wake_request_flag_o | (7'h01 << sel_q)) ==
             ($past(wake_request_flag_o) | $past(events) |
              (7'h01 << sel_q)));
    endproperty
    a_others_kept: assert property (p_others_kept)
        else $error("unrelated request lost");

    // no reset release while pin high
    property p_pin_hold;
        @(posedge core_clk_i) disable iff (rst_i)
        reset_pin_i |=> sys_reset_o;
    endproperty
    a_pin_hold: assert property (p_pin_hold)
        else $error("reset released while pin high");

    property p_wdf_clear;
        @(posedge core_clk_i) disable iff (rst_i)
        (reset_pin_i || por_req) |=> !watchdog_enable_flag_o;
    endproperty
    a_wdf_clear: assert property (p_wdf_clear)
        else $error("watchdog flag survived hard reset");

    property p_wdf_set;
        @(posedge core_clk_i) disable iff (rst_i)
        (wd.clear && !hard_reset) |=> watchdog_enable_flag_o;
    endproperty
    a_wdf_set: assert property (p_wdf_set)
        else $error("watchdog not enabled");

    property p_nop_first;
        @(posedge core_clk_i) disable iff (rst_i || sys_reset_o)
        accept |=> nop_insert_o;
    endproperty
    a_nop_first: assert property (p_nop_first)
        else $error("nop not inserted");
endmodule
`default_nettype wire

// ---- testbench/irwd_cpu_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// cpu sequencer and prescaler stand-in
module irwd_cpu_model #(
    parameter int MC_GAP = 3
) (
    input  wire logic core_clk_i,
    output var logic  stage0_tick_o,
    output var logic  stage10_tick_o,
    output var logic  machine_cycle_o,
    output var logic  instr_boundary_o,
    output var logic  key_scan_clk_o
);
    logic [7:0] div;
    initial begin
        div = 8'h00;
        stage0_tick_o = 1'b0;
        stage10_tick_o = 1'b0;
        machine_cycle_o = 1'b0;
        instr_boundary_o = 1'b0;
        key_scan_clk_o = 1'b0;
    end
    // odd gap keeps machine cycles out of step with the ticks
    always @(posedge core_clk_i) begin
        div              <= div + 8'h01;
        stage0_tick_o    <= div[0];
        stage10_tick_o   <= (div[1:0] == 2'h3);
        machine_cycle_o  <= ((div % MC_GAP) == 0);
        // slow side: some cycles sit inside a long instruction
        instr_boundary_o <= (div[4:2] != 3'h5);
        key_scan_clk_o   <= (div[3:0] == 4'hF);
    end
endmodule
`default_nettype wire

// ---- testbench/interrupt_reset_watchdog_ctrl_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// bench
module interrupt_reset_watchdog_ctrl_tb;
    import irwd_pkg::*;
    localparam int RST_CNT = 8;
    logic        core_clk_i, rst_i, por_i, reset_pin_i, key_scan_mode_i;
    logic [3:0]  key_in_i;
    logic        key_scan_clk_i, stage0_tick_i, stage10_tick_i;
    logic        machine_cycle_i, instr_boundary_i, cur_is_halt_i;
    logic        halt_mode_i, stop_mode_i, counter_control_pin_mode_i;
    logic [11:0] cur_pc_i, stack_data_o, pc_value_o;
    logic [6:0]  ev, mask, wake_request_flag_o, irq_enable_flag_o;
    logic        set_irq_enables_instr_i, clear_wake_requests_instr_i;
    logic [6:0]  set_irq_enables_data_i, clear_wake_requests_data_i;
    logic        set_flag_instr_i, watchdog_enable_flag_o;
    logic [7:0]  set_flag_opnd_i;
    logic        stack_push_o, pc_load_o, nop_insert_o, rehalt_pending_o;
    logic        sys_reset_o, wd_reset_o;
    int          error_cnt = 0;
    int          checked = 0;
    int          i, k, n;
    int          ord [7] = '{SRC_PRE, SRC_TIM1, SRC_TIM2, SRC_RCNV,
                             SRC_PORTC, SRC_EXT, SRC_KEY};
    logic [11:0] vecs [7] = '{VEC_PRE, VEC_TIM1, VEC_TIM2, VEC_RCNV,
                              VEC_PORTC, VEC_EXT, VEC_KEY};

    irwd_ctrl #(.WD_SEL(WD_SEL_8), .RST_LONG(RST_CNT), .RST_SHORT(4)) uut (
        .core_clk_i, .rst_i, .por_i, .reset_pin_i, .key_in_i,
        .key_scan_mode_i, .key_scan_clk_i, .stage0_tick_i, .stage10_tick_i,
        .machine_cycle_i, .instr_boundary_i, .cur_pc_i, .cur_is_halt_i,
        .halt_mode_i, .stop_mode_i, .counter_control_pin_mode_i,
        .timer_one_uflow_i(ev[SRC_TIM1]), .timer_two_uflow_i(ev[SRC_TIM2]),
        .prescaler_ovf_i(ev[SRC_PRE]), .counter_stop_i(ev[SRC_RCNV]),
        .port_c_match_i(ev[SRC_PORTC]), .ext_edge_match_i(ev[SRC_EXT]),
        .key_scan_event_i(ev[SRC_KEY]), .set_irq_enables_instr_i,
        .set_irq_enables_data_i, .clear_wake_requests_instr_i,
        .clear_wake_requests_data_i, .set_flag_instr_i, .set_flag_opnd_i,
        .wake_request_flag_o, .irq_enable_flag_o, .watchdog_enable_flag_o,
        .stack_push_o, .stack_data_o, .pc_load_o, .pc_value_o, .nop_insert_o,
        .rehalt_pending_o, .sys_reset_o, .wd_reset_o
    );
    irwd_cpu_model #(.MC_GAP(3)) partner (
        .core_clk_i,
        .stage0_tick_o(stage0_tick_i),
        .stage10_tick_o(stage10_tick_i),
        .machine_cycle_o(machine_cycle_i),
        .instr_boundary_o(instr_boundary_i),
        .key_scan_clk_o(key_scan_clk_i)
    );

    initial begin
        core_clk_i = 1'b0;
        forever #10 core_clk_i = ~core_clk_i;
    end

    task automatic chk_v(input logic [11:0] got, input logic [11:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_b(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t flag %b want %b", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic timeout;
        error_cnt++;
        $display("CHECK FAILED %0t wait ran out", $time);
        end_of_test();
    endtask
    task automatic wait_rst(input logic lvl, input int lim);
        for (int w = 0; sys_reset_o !== lvl; w++) begin
            if (w >= lim) timeout();
            @(posedge core_clk_i);
            #1;
        end
    endtask
    // w: 0 set enables, 1 clear requests, 2 set flag
    task automatic op(input int w, input logic [7:0] d);
        @(posedge core_clk_i);
        set_irq_enables_instr_i <= (w == 0);
        clear_wake_requests_instr_i <= (w == 1);
        set_flag_instr_i <= (w == 2);
        set_irq_enables_data_i <= d[6:0];
        clear_wake_requests_data_i <= d[6:0];
        set_flag_opnd_i <= d;
        @(posedge core_clk_i);
        set_irq_enables_instr_i <= 1'b0;
        clear_wake_requests_instr_i <= 1'b0;
        set_flag_instr_i <= 1'b0;
        #1;
    endtask
    task automatic pulse(input logic [6:0] m);
        @(posedge core_clk_i);
        ev <= m;
        @(posedge core_clk_i);
        ev <= 7'h00;
        #1;
    endtask
    // expected winner: highest priority among pending and enabled
    function automatic int exp_pick(input logic [6:0] p);
        exp_pick = SRC_KEY;
        for (int j = 6; j >= 0; j--) begin
            if (p[ord[j]]) exp_pick = ord[j];
        end
    endfunction
    function automatic logic [11:0] exp_vec(input int s);
        exp_vec = VEC_KEY;
        for (int j = 0; j < 7; j++) begin
            if (ord[j] == s) exp_vec = vecs[j];
        end
    endfunction
    // requests must be pending before the enables open the gate
    task automatic disp(input logic [6:0] e);
        logic [6:0] prior;
        logic       saw;
        int         t;
        int         b;
        prior = wake_request_flag_o;
        b = exp_pick(prior & e);
        saw = 1'b0;
        op(0, {1'b0, e});
        for (t = 0; pc_load_o !== 1'b1; t++) begin
            if (t >= 60) timeout();
            @(posedge core_clk_i);
            #1;
            saw = saw | (stack_push_o === 1'b1 && nop_insert_o === 1'b1);
        end
        chk_b(saw, 1'b1);
        chk_v(pc_value_o, exp_vec(b));
        chk_v(stack_data_o, cur_pc_i);
        chk_v({5'h00, irq_enable_flag_o}, 12'h000);
        chk_v({5'h00, wake_request_flag_o},
              {5'h00, prior & ~(7'h01 << b)});
    endtask

    initial begin
        {por_i, reset_pin_i, key_scan_mode_i, cur_is_halt_i} = 4'h0;
        {halt_mode_i, stop_mode_i, set_flag_instr_i} = 3'h0;
        {set_irq_enables_instr_i, clear_wake_requests_instr_i} = 2'h0;
        set_irq_enables_data_i = 7'h00;
        clear_wake_requests_data_i = 7'h00;
        set_flag_opnd_i = 8'h00;
        ev = 7'h00;
        cur_pc_i = 12'h000;
        key_in_i = 4'hF;
        counter_control_pin_mode_i = 1'b1;
        rst_i = 1'b1;
        void'($urandom(30));
        repeat (5) @(posedge core_clk_i);
        rst_i <= 1'b0;
        wait_rst(1'b0, 200);
        chk_v(pc_value_o, PC_RESET);
        chk_v({5'h00, irq_enable_flag_o}, 12'h000);
        chk_v({5'h00, wake_request_flag_o}, 12'h000);
        chk_b(watchdog_enable_flag_o, 1'b0);
        // ====================================================
        // all seven at once, enables reopened minus served ones
        op(1, 8'h7F);
        pulse(7'h7F);
        mask = 7'h7F;
        for (i = 0; i < 7; i++) begin
            @(posedge core_clk_i);
            cur_pc_i <= 12'($urandom);
            cur_is_halt_i <= (i == 6);
            #1;
            disp(mask);
            mask = mask & ~(7'h01 << ord[i]);
        end
        chk_b(rehalt_pending_o, 1'b1);
        for (i = 0; i < 10; i++) begin
            k = $urandom_range(6);
            @(posedge core_clk_i);
            cur_pc_i <= 12'($urandom);
            cur_is_halt_i <= 1'b0;
            pulse(7'h01 << ord[k]);
            disp(7'h7F);
        end
        @(posedge core_clk_i);
        counter_control_pin_mode_i <= 1'b0;
        pulse(7'h01 << SRC_RCNV);
        chk_v({5'h00, wake_request_flag_o}, 12'h000);
        // ====================================================
        // key and power-on resets; one key high blocks it
        @(posedge core_clk_i);
        counter_control_pin_mode_i <= 1'b1;
        key_in_i <= 4'h1;
        repeat (20) @(posedge core_clk_i);
        #1;
        chk_b(sys_reset_o, 1'b0);
        for (i = 0; i < 3; i++) begin
            @(posedge core_clk_i);
            key_scan_mode_i <= (i == 1);
            key_in_i <= (i == 2) ? 4'hF : 4'h0;
            por_i <= (i == 2);
            wait_rst(1'b1, 40);
            @(posedge core_clk_i);
            key_in_i <= 4'hF;
            por_i <= 1'b0;
            wait_rst(1'b0, 200);
        end
        // ====================================================
        // watchdog: wrong operand, kicks, freeze, overflow
        op(2, 8'h11);
        chk_b(watchdog_enable_flag_o, 1'b0);
        op(2, WD_KICK_OPND);
        chk_b(watchdog_enable_flag_o, 1'b1);
        repeat (8) begin
            repeat (20) @(posedge core_clk_i);
            op(2, WD_KICK_OPND);
        end
        chk_b(sys_reset_o, 1'b0);
        n = 0;
        for (k = 0; k < 300 && sys_reset_o !== 1'b1; k++) begin
            @(posedge core_clk_i);
            halt_mode_i <= (k < 40);
            stop_mode_i <= (k >= 40 && k < 80);
            #1;
            if (stage10_tick_i === 1'b1 && !halt_mode_i && !stop_mode_i) n++;
        end
        if (sys_reset_o !== 1'b1) timeout();
        chk_b(k >= 80, 1'b1);
        chk_b(n >= 7 && n <= 9, 1'b1);
        repeat (2) @(posedge core_clk_i);
        #1;
        chk_b(wd_reset_o, 1'b1);
        chk_b(watchdog_enable_flag_o, 1'b1);
        // ====================================================
        // pin reset holds without counting, then full cycle
        @(posedge core_clk_i);
        reset_pin_i <= 1'b1;
        repeat (50) @(posedge core_clk_i);
        #1;
        chk_b(sys_reset_o, 1'b1);
        chk_b(watchdog_enable_flag_o, 1'b0);
        @(posedge core_clk_i);
        reset_pin_i <= 1'b0;
        n = 0;
        for (k = 0; k < 100 && sys_reset_o !== 1'b0; k++) begin
            @(posedge core_clk_i);
            #1;
            if (stage0_tick_i === 1'b1) n++;
        end
        if (sys_reset_o !== 1'b0) timeout();
        chk_b(n >= RST_CNT - 1 && n <= RST_CNT + 1, 1'b1);
        chk_v(pc_value_o, PC_RESET);
        end_of_test();
    end
endmodule
`default_nettype wire
